// >>> lcdr_tick_div.sv
`timescale 1ns/100ps

// Counts enable pulses and emits a one-cycle tick on every COUNT-th one.
// Used both for the row rate and for the blink rate, which is a count of frames.
module lcdr_tick_div #(
  parameter int unsigned COUNT = 4
) (
  input  wire logic clock_i,  // System clock.
  input  wire logic srst_i,   // Synchronous reset, active high.
  input  wire logic en_i,     // One-cycle pulse to be counted.
  output logic      tick_o    // One-cycle pulse after COUNT enables.
);

  // Counter width follows the count so that no bit is wasted.
  localparam int unsigned CNT_W = (COUNT > 1) ? $clog2(COUNT) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(COUNT - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  logic [CNT_W-1:0] cnt_ff;       // Enables seen since the last tick.
  logic [CNT_W-1:0] nxt_cnt;      // Next value of the counter.
  logic             tick_ff;      // Registered tick output.
  logic             nxt_tick;     // Next value of the tick.

  // The tick is raised in the cycle after the last enable of a group.
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (en_i) begin
      if (cnt_ff == CNT_LAST) begin
        nxt_cnt  = CNT_ZERO;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + CNT_ONE;
      end
    end
  end

  // Registers only.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cnt_ff  <= CNT_ZERO;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

endmodule

// >>> lcdr_refresh.sv
`timescale 1ns/100ps

// Constants shared by the refresh path.
package lcdr_pkg;
  localparam int unsigned SEG_N     = 60;          // Segment drivers.
  localparam int unsigned COM_N     = 34;          // Common drivers, numbered 0 to 33.
  localparam int unsigned ADDR_W    = 7;           // Character memory address width.
  localparam int unsigned PAT_W     = 6;           // Widest font row in dots.
  localparam int unsigned COM_W     = 6;           // Width of a common index.
  localparam logic [2:0]  FONT_W5   = 3'h5;        // Dots per character, narrow font.
  localparam logic [2:0]  FONT_W6   = 3'h6;        // Dots per character, wide font.
  localparam logic [3:0]  CHARS_W5  = 4'hc;        // Characters across 60 dots, narrow.
  localparam logic [3:0]  CHARS_W6  = 4'ha;        // Characters across 60 dots, wide.
  localparam logic [2:0]  CURSOR_ROW = 3'h7;       // Dot row that carries the underline.
  localparam logic [5:0]  COM_ICON_FIRST = 6'h00;  // First icon common.
  localparam logic [5:0]  COM_ICON_1L    = 6'h11;  // Last icon common, one-line mode.
  localparam logic [5:0]  COM_ICON_NL    = 6'h21;  // Last icon common, two or four lines.
  localparam logic [6:0]  LINE2_BASE     = 7'h40;  // Start of the second line.
  localparam logic [6:0]  QUAD_STEP      = 7'h20;  // Address step between four lines.
  localparam int unsigned CLK_PERIOD_NS  = 10;     // 100 MHz system clock.
  localparam int unsigned ROW_TIME_NS    = 2560;   // Time given to one common row.
  localparam int unsigned ROW_CYCLES     = ROW_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned BLINK_FRAMES   = 32;     // Frames per blink half period.
endpackage

// Behaviour
// - Drive 34 commons and 60 segments from refresh.
// - Unused commons stay in non-selection.
// - Shift bits serially, latch when complete.
// - Load from highest used address downward.
// - Latch when starting address pattern enters.
// - Cursor or blink at address pointer position.
// - Scroll horizontally one dot per step.
// - Pointer steps by one per memory access.
// - Icon memory drives the two icon commons.
// - Two-line: line one commons 1-16, two 17-32.
module lcdr_refresh
  import lcdr_pkg::*;
#(
  parameter int unsigned ROW_DIV = lcdr_pkg::ROW_CYCLES,   // Cycles per common row.
  parameter int unsigned BLINK_DIV = lcdr_pkg::BLINK_FRAMES // Frames per blink phase.
) (
  input  wire logic                          clock_i,             // System clock.
  input  wire logic                          srst_i,              // Synchronous reset.
  input  wire logic                          display_on_i,        // Segments enabled.
  input  wire logic                          two_line_select_i,   // Two-line mode.
  input  wire logic                          four_line_select_i,  // Four-line mode.
  input  wire logic                          font_wide_i,         // Six-dot font width.
  input  wire logic                          cursor_en_i,         // Underline cursor on.
  input  wire logic                          blink_en_i,          // Blink area on.
  input  wire logic                          blink_invert_i,      // Blink by inversion.
  input  wire logic [lcdr_pkg::ADDR_W-1:0]   start_addr_i,        // Display start address.
  input  wire logic [2:0]                    scroll_dots_i,       // Dot scroll offset.
  input  wire logic                          mem_access_i,        // Memory read or write.
  input  wire logic                          addr_load_i,         // Load the pointer.
  input  wire logic [lcdr_pkg::ADDR_W-1:0]   addr_value_i,        // Value to load.
  input  wire logic                          addr_decrement_i,    // Step down, not up.
  input  wire logic [lcdr_pkg::PAT_W-1:0]    pattern_row_i,       // Fetched pattern row.
  input  wire logic [lcdr_pkg::SEG_N-1:0]    icon_first_i,        // Icon bits, first row.
  input  wire logic [lcdr_pkg::SEG_N-1:0]    icon_last_i,         // Icon bits, last row.
  output logic      [lcdr_pkg::SEG_N-1:0]    seg_o,               // Latched segment data.
  output logic      [lcdr_pkg::COM_N-1:0]    common_drive_output_o, // Selected common.
  output logic                               frame_pol_o,         // Drive polarity.
  output logic      [lcdr_pkg::ADDR_W-1:0]   fetch_addr_o,        // Character to fetch.
  output logic      [2:0]                    fetch_row_o,         // Dot row to fetch.
  output logic                               fetch_req_o,         // Fetch strobe.
  output logic      [lcdr_pkg::ADDR_W-1:0]   display_address_pointer_o // Pointer value.
);
  import lcdr_pkg::*;

  // Load sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_WAIT,
    ST_CAPT,
    ST_SHIFT
  } lcdr_state_e;

  localparam logic [COM_W-1:0]  COM_ONE  = COM_W'(1);
  localparam logic [ADDR_W-1:0] ADDR_ONE = ADDR_W'(1);
  localparam logic [ADDR_W-1:0] ADDR_ZERO = '0;

  lcdr_state_e         state_ff, nxt_state;       // Sequencer state.
  logic [SEG_N-1:0]    shift_ff, nxt_shift;       // Serial shift register.
  logic [SEG_N-1:0]    seg_ff, nxt_seg;           // Segment latch.
  logic [COM_N-1:0]    com_sel_ff, nxt_com_sel;   // One-hot selected common.
  logic [COM_W-1:0]    com_ff, nxt_com;           // Common being prepared.
  logic                pol_ff, nxt_pol;           // Frame polarity.
  logic                frame_end_ff, nxt_frame_end; // Pulse at the end of a frame.
  logic                blink_ph_ff, nxt_blink_ph; // Blink phase.
  logic [ADDR_W-1:0]   base_ff, nxt_base;         // Address of the line start.
  logic [2:0]          row_ff, nxt_row;           // Dot row within the character.
  logic [3:0]          char_ff, nxt_char;         // Characters left to load.
  logic [2:0]          col_ff, nxt_col;           // Column within the character.
  logic [PAT_W-1:0]    pat_ff, nxt_pat;           // Pattern row being shifted.
  logic [ADDR_W-1:0]   faddr_ff, nxt_faddr;       // Fetch address register.
  logic [2:0]          frow_ff, nxt_frow;         // Fetch row register.
  logic                freq_ff, nxt_freq;         // Fetch strobe register.
  logic [ADDR_W-1:0]   ptr_ff, nxt_ptr;           // Address pointer.

  logic                row_tick;                  // Start of a common row.
  logic                blink_tick;                // End of a blink phase.
  logic [2:0]          font_w;                    // Dots per character.
  logic [3:0]          chars;                     // Characters across the panel.
  logic [2:0]          scroll;                    // Scroll offset kept below font_w.
  logic [COM_W-1:0]    com_last;                  // Last common scanned this mode.
  logic [COM_W-1:0]    com_m1;                    // Text common index from zero.
  logic [ADDR_W-1:0]   line_off;                  // Line start offset for this common.
  logic [PAT_W-1:0]    pat_mod;                   // Pattern after cursor and blink.

  // The row rate comes from the system clock through a divider.
  lcdr_tick_div #(.COUNT(ROW_DIV)) u_row_div (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .en_i    (1'b1),
    .tick_o  (row_tick)
  );

  // The blink phase flips after a fixed number of whole frames.
  lcdr_tick_div #(.COUNT(BLINK_DIV)) u_blink_div (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .en_i    (frame_end_ff),
    .tick_o  (blink_tick)
  );

  // Mode decode: font width, characters per row and scan length.
  always_comb begin
    font_w   = font_wide_i ? FONT_W6 : FONT_W5;
    chars    = font_wide_i ? CHARS_W6 : CHARS_W5;
    // A scroll offset of a whole character or more is treated as none.
    scroll   = (scroll_dots_i < font_w) ? scroll_dots_i : 3'h0;
    // One line uses commons 0 to 17, more lines use 0 to 33; the rest never select.
    com_last = (two_line_select_i || four_line_select_i) ? COM_ICON_NL : COM_ICON_1L;
    com_m1   = com_ff - COM_ONE;
    // Every block of eight commons shows one band of character rows.
    if (four_line_select_i) begin
      line_off = 7'(com_m1[4:3] * QUAD_STEP);
    end else if (two_line_select_i) begin
      // First line on commons 1 to 16, second line on commons 17 to 32.
      line_off = (com_m1[4] ? LINE2_BASE : ADDR_ZERO)
               + (com_m1[3] ? 7'(chars) : ADDR_ZERO);
    end else begin
      line_off = com_m1[3] ? 7'(chars) : ADDR_ZERO;
    end
  end

  // Cursor and blink area are painted on the character under the pointer.
  always_comb begin
    pat_mod = pattern_row_i;
    if (faddr_ff == ptr_ff) begin
      if (cursor_en_i && (frow_ff == CURSOR_ROW)) begin
        pat_mod = '1;
      end
      if (blink_en_i && blink_ph_ff) begin
        pat_mod = blink_invert_i ? ~pattern_row_i : '1;
      end
    end
  end

  // Next-state logic for the pointer, the scan and the serial loader.
  always_comb begin
    nxt_state     = state_ff;
    nxt_shift     = shift_ff;
    nxt_seg       = seg_ff;
    nxt_com_sel   = com_sel_ff;
    nxt_com       = com_ff;
    nxt_pol       = pol_ff;
    nxt_frame_end = 1'b0;
    nxt_blink_ph  = blink_tick ? ~blink_ph_ff : blink_ph_ff;
    nxt_base      = base_ff;
    nxt_row       = row_ff;
    nxt_char      = char_ff;
    nxt_col       = col_ff;
    nxt_pat       = pat_ff;
    nxt_faddr     = faddr_ff;
    nxt_frow      = frow_ff;
    nxt_freq      = 1'b0;
    nxt_ptr       = ptr_ff;

    // A load wins over a step; each access moves the pointer by one.
    if (addr_load_i) begin
      nxt_ptr = addr_value_i;
    end else if (mem_access_i) begin
      nxt_ptr = addr_decrement_i ? ptr_ff - ADDR_ONE : ptr_ff + ADDR_ONE;
    end

    case (state_ff)
      // Wait for the next row slot; icon rows latch at once.
      ST_IDLE: begin
        if (row_tick) begin
          if ((com_ff == COM_ICON_FIRST) || (com_ff == com_last)) begin
            nxt_seg = (com_ff == COM_ICON_FIRST) ? icon_first_i : icon_last_i;
            if (!display_on_i) begin
              nxt_seg = '0;
            end
            nxt_com_sel         = '0;
            nxt_com_sel[com_ff] = 1'b1;
            nxt_pol             = (com_ff == com_last) ? ~pol_ff : pol_ff;
            nxt_frame_end       = (com_ff == com_last);
            nxt_com             = (com_ff == com_last) ? COM_ICON_FIRST : com_ff + COM_ONE;
          end else begin
            nxt_base  = start_addr_i + line_off;
            nxt_row   = com_m1[2:0];
            // One extra character to the right fills the scrolled-in dots.
            nxt_char  = chars;
            nxt_state = ST_FETCH;
          end
        end
      end
      // Present the address of the next character, highest first.
      ST_FETCH: begin
        nxt_faddr = base_ff + 7'(char_ff);
        nxt_frow  = row_ff;
        nxt_freq  = 1'b1;
        nxt_state = ST_WAIT;
      end
      // The pattern memory answers one cycle after it samples the address.
      ST_WAIT: begin
        nxt_state = ST_CAPT;
      end
      // Take the pattern row and start at its rightmost dot.
      ST_CAPT: begin
        nxt_pat   = pat_mod;
        nxt_col   = 3'h0;
        nxt_state = ST_SHIFT;
      end
      // One dot per cycle into the shift register.
      ST_SHIFT: begin
        nxt_shift = {shift_ff[SEG_N-2:0], pat_ff[col_ff]};
        if ((char_ff == 4'h0) && (col_ff == 3'(font_w - 3'h1 - scroll))) begin
          // The start character is in: the leftmost dots are dropped by the scroll.
          nxt_seg             = display_on_i ? nxt_shift : '0;
          nxt_com_sel         = '0;
          nxt_com_sel[com_ff] = 1'b1;
          nxt_com             = com_ff + COM_ONE;
          nxt_state           = ST_IDLE;
        end else if (col_ff == 3'(font_w - 3'h1)) begin
          nxt_char  = char_ff - 4'h1;
          nxt_state = ST_FETCH;
        end else begin
          nxt_col = col_ff + 3'h1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_ff     <= ST_IDLE;
      shift_ff     <= '0;
      seg_ff       <= '0;
      com_sel_ff   <= '0;
      com_ff       <= COM_ICON_FIRST;
      pol_ff       <= 1'b0;
      frame_end_ff <= 1'b0;
      blink_ph_ff  <= 1'b0;
      base_ff      <= '0;
      row_ff       <= 3'h0;
      char_ff      <= 4'h0;
      col_ff       <= 3'h0;
      pat_ff       <= '0;
      faddr_ff     <= '0;
      frow_ff      <= 3'h0;
      freq_ff      <= 1'b0;
      ptr_ff       <= '0;
    end else begin
      state_ff     <= nxt_state;
      shift_ff     <= nxt_shift;
      seg_ff       <= nxt_seg;
      com_sel_ff   <= nxt_com_sel;
      com_ff       <= nxt_com;
      pol_ff       <= nxt_pol;
      frame_end_ff <= nxt_frame_end;
      blink_ph_ff  <= nxt_blink_ph;
      base_ff      <= nxt_base;
      row_ff       <= nxt_row;
      char_ff      <= nxt_char;
      col_ff       <= nxt_col;
      pat_ff       <= nxt_pat;
      faddr_ff     <= nxt_faddr;
      frow_ff      <= nxt_frow;
      freq_ff      <= nxt_freq;
      ptr_ff       <= nxt_ptr;
    end
  end

  // All outputs come straight from registers.
  assign seg_o                     = seg_ff;
  assign common_drive_output_o     = com_sel_ff;
  assign frame_pol_o               = pol_ff;
  assign fetch_addr_o              = faddr_ff;
  assign fetch_row_o               = frow_ff;
  assign fetch_req_o               = freq_ff;
  assign display_address_pointer_o = ptr_ff;

endmodule

// >>> lcdr_glyph_model.sv
`timescale 1ns/100ps

// Pattern memory on the far side of the fetch port.
// Data is valid only in the cycle after a request; otherwise the bus toggles,
// so a late capture by the design shows up as wrong dots.
module lcdr_glyph_model (
  input  wire logic       clock_i,    // System clock.
  input  wire logic       req_i,      // Fetch strobe from the design.
  input  wire logic [6:0] addr_i,     // Character address to fetch.
  input  wire logic [2:0] row_i,      // Dot row to fetch.
  output logic      [5:0] pattern_o   // Pattern row back to the design.
);
  // Answer one cycle after the strobe, then spoil the bus.
  initial pattern_o = 6'h00;
  always @(posedge clock_i) begin
    if (req_i) begin
      pattern_o <= addr_i[5:0] ^ {3'h0, row_i};
    end else begin
      pattern_o <= ~pattern_o;
    end
  end
endmodule

// >>> lcdr_refresh_chk.sv
`timescale 1ns/100ps

// Watches the refresh path ports for pointer, fetch and common behaviour.
module lcdr_refresh_chk (
  input  wire logic        clock_i,               // System clock.
  input  wire logic        srst_i,                // Synchronous reset.
  input  wire logic        display_on_i,          // Segments enabled.
  input  wire logic        two_line_select_i,     // Two-line mode.
  input  wire logic        four_line_select_i,    // Four-line mode.
  input  wire logic        mem_access_i,          // Memory access pulse.
  input  wire logic        addr_load_i,           // Pointer load pulse.
  input  wire logic [6:0]  addr_value_i,          // Pointer load value.
  input  wire logic        addr_decrement_i,      // Step down.
  input  wire logic [59:0] icon_first_i,          // Icon bits, first row.
  input  wire logic [59:0] seg_o,                 // Latched segments.
  input  wire logic [33:0] common_drive_output_o, // Selected common.
  input  wire logic [6:0]  fetch_addr_o,          // Fetch address.
  input  wire logic        fetch_req_o,           // Fetch strobe.
  input  wire logic [6:0]  display_address_pointer_o // Pointer.
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);

  // A fetch strobe followed by the minimum quiet gap of a narrow font.
  sequence s_fetch_gap;
    fetch_req_o ##1 !fetch_req_o [*7];
  endsequence

  ptr_step_up_a: assert property (mem_access_i && !addr_load_i && !addr_decrement_i
    |=> display_address_pointer_o == $past(display_address_pointer_o) + 7'h01)
    else $error("pointer did not step up");
  ptr_step_down_a: assert property (mem_access_i && !addr_load_i && addr_decrement_i
    |=> display_address_pointer_o == $past(display_address_pointer_o) - 7'h01)
    else $error("pointer did not step down");
  ptr_load_a: assert property (addr_load_i
    |=> display_address_pointer_o == $past(addr_value_i))
    else $error("pointer load lost");
  ptr_hold_a: assert property (!mem_access_i && !addr_load_i
    |=> $stable(display_address_pointer_o))
    else $error("pointer moved without access");
  fetch_gap_a: assert property (fetch_req_o |-> s_fetch_gap)
    else $error("fetches too close");
  fetch_hold_a: assert property (!fetch_req_o |-> $stable(fetch_addr_o))
    else $error("fetch address changed without strobe");
  com_onehot_a: assert property ($onehot0(common_drive_output_o))
    else $error("more than one common selected");
  com_unused_a: assert property (!two_line_select_i && !four_line_select_i
    |-> common_drive_output_o[33:18] == 16'h0000)
    else $error("unused common selected");
  icon_first_a: assert property (common_drive_output_o[0] && display_on_i
    |-> seg_o == icon_first_i)
    else $error("first icon row wrong");
  reset_clear_a: assert property (disable iff (1'b0) srst_i
    |=> seg_o == 60'h0 && common_drive_output_o == 34'h0)
    else $error("outputs not cleared by reset");
endmodule

bind lcdr_refresh lcdr_refresh_chk i_lcdr_refresh_chk (
  .clock_i(clock_i), .srst_i(srst_i), .display_on_i(display_on_i),
  .two_line_select_i(two_line_select_i), .four_line_select_i(four_line_select_i),
  .mem_access_i(mem_access_i), .addr_load_i(addr_load_i), .addr_value_i(addr_value_i),
  .addr_decrement_i(addr_decrement_i), .icon_first_i(icon_first_i), .seg_o(seg_o),
  .common_drive_output_o(common_drive_output_o), .fetch_addr_o(fetch_addr_o),
  .fetch_req_o(fetch_req_o), .display_address_pointer_o(display_address_pointer_o)
);

// >>> lcdr_refresh_tb_top.sv
`timescale 1ns/100ps

// Drives the refresh path and judges pointer, fetch order and common scan.
module lcdr_refresh_tb_top;
  import lcdr_pkg::*;
  logic        clock_i, srst_i, display_on_i, two_line_select_i, four_line_select_i;
  logic        font_wide_i, cursor_en_i, mem_access_i, addr_load_i, addr_decrement_i;
  logic [6:0]  start_addr_i, addr_value_i, fetch_addr_o, ptr;
  logic [5:0]  pattern_row_i;
  logic [2:0]  fetch_row_o, scroll_dots_i;
  logic [59:0] icon_first_i, icon_last_i, seg_o;
  logic [33:0] common_drive_output;
  logic        frame_pol_o, fetch_req_o, blink_en_i, blink_invert_i;
  int          n_mismatch, comparisons;

  // Design with a short row time and blink period.
  lcdr_refresh #(.ROW_DIV(128), .BLINK_DIV(2)) i_lcdr_refresh (
    .clock_i(clock_i), .srst_i(srst_i), .display_on_i(display_on_i),
    .two_line_select_i(two_line_select_i), .four_line_select_i(four_line_select_i),
    .font_wide_i(font_wide_i), .cursor_en_i(cursor_en_i), .blink_en_i(blink_en_i),
    .blink_invert_i(blink_invert_i), .start_addr_i(start_addr_i),
    .scroll_dots_i(scroll_dots_i),
    .mem_access_i(mem_access_i), .addr_load_i(addr_load_i), .addr_value_i(addr_value_i),
    .addr_decrement_i(addr_decrement_i), .pattern_row_i(pattern_row_i),
    .icon_first_i(icon_first_i), .icon_last_i(icon_last_i), .seg_o(seg_o),
    .common_drive_output_o(common_drive_output), .frame_pol_o(frame_pol_o), .fetch_addr_o(fetch_addr_o),
    .fetch_row_o(fetch_row_o), .fetch_req_o(fetch_req_o), .display_address_pointer_o(ptr));

  // Pattern memory standing in for the far side.
  lcdr_glyph_model i_lcdr_glyph_model (.clock_i(clock_i), .req_i(fetch_req_o),
    .addr_i(fetch_addr_o), .row_i(fetch_row_o), .pattern_o(pattern_row_i));

  // Free-running 100 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Pointer wraps both ways, and a load beats a same-cycle access.
  task automatic t_pointer;
    addr_value_i = 7'h7e;
    addr_load_i = 1'b1;
    @(negedge clock_i);
    addr_load_i = 1'b0;
    mem_access_i = 1'b1;
    repeat (3) @(negedge clock_i);
    check(ptr === 7'h01, "pointer up wrap");
    addr_decrement_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check(ptr === 7'h7f, "pointer down wrap");
    addr_value_i = 7'h05;
    addr_load_i = 1'b1;
    @(negedge clock_i);
    {mem_access_i, addr_load_i, addr_decrement_i} = 3'h0;
    @(negedge clock_i);
    check(ptr === 7'h05, "load lost to access");
  endtask

  // One text row: fetches run from the extra character down to the start,
  // then the row is latched with the start character leftmost.
  task automatic t_fetch;
    logic [2:0] r;
    logic [5:0] p;
    int         n;
    n = 0;
    while (!(fetch_req_o === 1'b1 && fetch_addr_o === 7'h11) && n < 3000) begin
      @(negedge clock_i);
      n++;
    end
    r = fetch_row_o;
    for (int i = 1; i <= 12; i++) begin
      n = 0;
      do begin
        @(negedge clock_i);
        n++;
      end while (fetch_req_o !== 1'b1 && n < 20);
      check(fetch_addr_o === 7'h11 - 7'(i) && fetch_row_o === r, "fetch order");
    end
    n = 0;
    while (common_drive_output[r + 1] !== 1'b1 && n < 30) begin
      @(negedge clock_i);
      n++;
    end
    p = 6'h05 ^ {3'h0, r};
    check(common_drive_output[r + 1] === 1'b1, "row not selected after load");
    check(seg_o[4:0] === {p[0], p[1], p[2], p[3], p[4]}, "start dots wrong");
  endtask

  // Waits until common 1 is newly selected, at most one frame and a row.
  task automatic wait_row1;
    int n;
    n = 0;
    while (common_drive_output[1] !== 1'b0 && n < 300) begin
      @(negedge clock_i);
      n++;
    end
    while (common_drive_output[1] !== 1'b1 && n < 3000) begin
      @(negedge clock_i);
      n++;
    end
  endtask

  // A two-dot scroll drops the leftmost dots of the start character and fills
  // the right edge from the extra character; a blanked display latches zeros.
  task automatic t_scroll;
    logic [59:0] exp;
    logic [5:0]  p;
    scroll_dots_i = 3'h2;
    wait_row1();
    for (int d = 0; d < 60; d++) begin
      p = 6'h05 + 6'((d + 2) / 5);
      exp[d] = p[4 - (d + 2) % 5];
    end
    check(common_drive_output[1] === 1'b1 && seg_o === exp, "scrolled row wrong");
    display_on_i = 1'b0;
    wait_row1();
    check(common_drive_output[1] === 1'b1 && seg_o === 60'h0, "blanked row not zero");
    display_on_i = 1'b1;
    scroll_dots_i = 3'h0;
  endtask

  // The start character sits under the pointer: over four whole frames its
  // blink area shows in two, first as all dots on, then inverted.
  task automatic t_blink;
    logic [4:0] on_val;
    logic       pol;
    int         n_on, n_off;
    blink_en_i = 1'b1;
    for (int v = 0; v < 2; v++) begin
      blink_invert_i = (v == 1);
      on_val = (v == 1) ? 5'h0b : 5'h1f;
      n_on = 0;
      n_off = 0;
      for (int f = 0; f < 5; f++) begin
        pol = frame_pol_o;
        wait_row1();
        // The first frame may have started before the mode was set.
        if (f > 0) begin
          check(frame_pol_o === ~pol, "polarity not toggled");
          if (seg_o[4:0] === on_val) n_on++;
          else if (seg_o[4:0] === 5'h14) n_off++;
        end
      end
      check(n_on == 2 && n_off == 2, "blink phases wrong");
    end
    {blink_en_i, blink_invert_i} = 2'h0;
  endtask

  // Scans every line mode and checks which commons ever select,
  // the last icon row and the underline at the pointer.
  task automatic t_commons;
    logic [33:0] mask;
    int          last;
    for (int m = 0; m < 3; m++) begin
      two_line_select_i = (m == 1);
      four_line_select_i = (m == 2);
      font_wide_i = (m == 1);
      cursor_en_i = 1'b1;
      last = (m == 0) ? 17 : 33;
      mask = 34'h0;
      repeat (256) @(negedge clock_i);
      repeat (36 * 128) begin
        @(negedge clock_i);
        mask = mask | common_drive_output;
        if (common_drive_output[last] === 1'b1) check(seg_o === icon_last_i, "last icon row");
        if (common_drive_output[8] === 1'b1) check(seg_o[4:0] === 5'h1f, "cursor missing");
      end
      check(mask === ((m == 0) ? 34'h0003ffff : 34'h3ffffffff), "common set");
    end
  endtask

  // Watchdog against a hang; the scenarios take about 42600 cycles.
  initial begin
    repeat (60000) @(posedge clock_i);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  // Main sequence.
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    srst_i = 1'b1;
    display_on_i = 1'b1;
    {two_line_select_i, four_line_select_i, font_wide_i, cursor_en_i} = 4'h0;
    {blink_en_i, blink_invert_i, scroll_dots_i} = 5'h00;
    {mem_access_i, addr_load_i, addr_decrement_i} = 3'h0;
    start_addr_i = 7'h05;
    addr_value_i = 7'h00;
    icon_first_i = 60'h0123456789abcde;
    icon_last_i = 60'hfedcba987654321;
    repeat (4) @(negedge clock_i);
    srst_i = 1'b0;
    t_pointer();
    t_fetch();
    t_scroll();
    t_blink();
    t_commons();
    end_of_test();
  end
endmodule
